// file: verilog/fault_resp.sv
// Fault-response logic of a three-phase gate driver with an APB register port.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
// ****************************************
// Operation
// - A cycle limit event is a sensed current product above the cycle threshold.
// - Modes 0 and 1 recirculate until the next PWM cycle start, mode 0 reporting it.
// - Modes 2 and 3 recirculate until the current falls below the threshold, 2 reporting.
// - Modes 4 and 5 recirculate until elapsed PWM cycles exceed the retry count, 4 reporting.
// - Lock current modes apply Hi-Z, recirculation or brakes, latched or retried, 8 reports.
// - A position detection ramp longer than 500 ms latches a timeout fault with gates low.
// - A position pulse before the last current decayed latches a pulse rate fault.
// - Overtemperature pulls all gates low, reports, and auto recovers when enabled.
// - Without auto recovery the overtemperature shutdown stays until fault clear.
// - Pulled-low gates drive every high and low gate output actively low.
// - Disabled gates keep low gates on passive pull-down and high gates on semi-active.
// - The cycle limit flag is set on the event and cleared when driving resumes.
// ****************************************
module fault_resp #(
  parameter int unsigned IPD_TIMEOUT_CYCLES = fault_resp_pkg::IPD_TIMEOUT_CYC,
  parameter int unsigned LOCK_RETRY_CYCLES  = fault_resp_pkg::LOCK_RETRY_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   cycle_cmp_in,
  input  wire logic                   lock_cmp_in,
  input  wire logic                   overtemp_trip_in,
  input  wire logic                   pwm_cycle_start,
  input  wire logic                   ipd_ramp_up,
  input  wire logic                   ipd_ramp_down,
  input  wire logic                   ipd_pulse_start,
  input  wire logic                   ipd_current_decayed,
  input  wire logic                   gate_disable_req,
  input  wire fault_resp_pkg::gates_t gate_cmd,
  output fault_resp_pkg::gates_t      gate_out,
  output logic                        high_semi_pulldown,
  output logic                        low_active_pulldown,
  output logic                        fault_indicator_n,
  output fault_resp_pkg::status_t     fault_status
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (IPD_TIMEOUT_CYCLES < 2 || LOCK_RETRY_CYCLES < 2) begin : g_chk
    $error("Timing counts must be at least two cycles.");
  end

  localparam int unsigned IW = $clog2(IPD_TIMEOUT_CYCLES + 1);
  localparam int unsigned LW = $clog2(LOCK_RETRY_CYCLES + 1);

  // ****************************************
  // Registers and APB slave
  // ****************************************
  fault_resp_pkg::config_t cfg_q;
  fault_resp_pkg::status_t stat;
  logic                    wr_en;
  logic                    fault_clear;
  logic                    addr_ok;

  assign pready  = 1'b1;
  assign addr_ok = paddr == fault_resp_pkg::CONFIG_OFS || paddr == fault_resp_pkg::CLEAR_OFS
                   || paddr == fault_resp_pkg::STATUS_OFS;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = ce && psel && penable && pwrite;
  assign fault_clear = wr_en && paddr == fault_resp_pkg::CLEAR_OFS
                       && pwdata[fault_resp_pkg::CLEAR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= fault_resp_pkg::config_t'(fault_resp_pkg::CONFIG_RST[16:0]);
    end else if (wr_en && paddr == fault_resp_pkg::CONFIG_OFS) begin
      cfg_q.cyc_mode    <= pwdata[fault_resp_pkg::CYC_MODE_LSB +: 4];
      cfg_q.lock_mode   <= pwdata[fault_resp_pkg::LOCK_MODE_LSB +: 4];
      cfg_q.ot_auto     <= pwdata[fault_resp_pkg::OT_AUTO_BIT];
      cfg_q.retry_count <= pwdata[fault_resp_pkg::RETRY_LSB +: 8];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == fault_resp_pkg::CONFIG_OFS) begin
        prdata[fault_resp_pkg::CYC_MODE_LSB +: 4]  = cfg_q.cyc_mode;
        prdata[fault_resp_pkg::LOCK_MODE_LSB +: 4] = cfg_q.lock_mode;
        prdata[fault_resp_pkg::OT_AUTO_BIT]        = cfg_q.ot_auto;
        prdata[fault_resp_pkg::RETRY_LSB +: 8]     = cfg_q.retry_count;
      end else if (paddr == fault_resp_pkg::STATUS_OFS) begin
        prdata[7:0] = stat;
      end
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       cyc_cmp;
  logic       lock_cmp;
  logic       ot_trip;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else if (ce) begin
      meta_q <= {overtemp_trip_in, lock_cmp_in, cycle_cmp_in};
      sync_q <= meta_q;
    end
  end
  assign {ot_trip, lock_cmp, cyc_cmp} = sync_q;

  // ****************************************
  // Cycle-by-cycle limit
  // ****************************************
  logic       cyc_act_q;
  logic [8:0] pwm_cnt_q;
  logic       cyc_event;
  logic       cyc_clr;
  logic       cyc_rep;
  logic [3:0] cm;

  assign cm        = cfg_q.cyc_mode;
  assign cyc_event = cyc_cmp && cm < fault_resp_pkg::CYC_REPORT_ONLY;
  always_comb begin
    unique case (cm[3:1])
      3'h0:    cyc_clr = pwm_cycle_start;
      3'h1:    cyc_clr = !cyc_cmp;
      3'h2:    cyc_clr = pwm_cycle_start && pwm_cnt_q >= {1'b0, cfg_q.retry_count};
      default: cyc_clr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_act_q <= 1'b0;
    end else if (ce) begin
      cyc_act_q <= cyc_event || (cyc_act_q && !cyc_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_q <= 9'h000;
    end else if (ce) begin
      if (!cyc_act_q) begin
        pwm_cnt_q <= 9'h000;
      end else if (pwm_cycle_start) begin
        pwm_cnt_q <= pwm_cnt_q + 9'h001;
      end
    end
  end

  assign cyc_rep = (cyc_act_q && !cm[0] && cm < fault_resp_pkg::CYC_REPORT_ONLY)
                   || (cm == fault_resp_pkg::CYC_REPORT_ONLY && cyc_cmp);

  // ****************************************
  // Lock current limit
  // ****************************************
  logic          lock_act_q;
  logic [1:0]    lock_act_kind_q;
  logic [LW-1:0] lock_cnt_q;
  logic          lock_event;
  logic          lock_clr;
  logic          lock_rep;

  assign lock_event = lock_cmp && !cfg_q.lock_mode[3];
  assign lock_clr   = cfg_q.lock_mode[2] ? lock_cnt_q == LW'(LOCK_RETRY_CYCLES)
                                         : fault_clear;
  assign lock_rep   = lock_act_q || (cfg_q.lock_mode == fault_resp_pkg::LOCK_REPORT_ONLY
                                     && lock_cmp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_act_q      <= 1'b0;
      lock_act_kind_q <= 2'h0;
      lock_cnt_q      <= '0;
    end else if (ce) begin
      lock_act_q <= lock_event || (lock_act_q && !lock_clr);
      if (lock_event && !lock_act_q) begin
        lock_act_kind_q <= cfg_q.lock_mode[1:0];
      end
      lock_cnt_q <= (lock_act_q && !lock_clr) ? lock_cnt_q + LW'(1) : '0;
    end
  end

  // ****************************************
  // Position detection and thermal faults
  // ****************************************
  logic          t1_q;
  logic          t2_q;
  logic          rate_q;
  logic          ot_q;
  logic [IW-1:0] ipd_cnt_q;
  logic          ipd_over;

  assign ipd_over = ipd_cnt_q == IW'(IPD_TIMEOUT_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipd_cnt_q <= '0;
      t1_q      <= 1'b0;
      t2_q      <= 1'b0;
      rate_q    <= 1'b0;
    end else if (ce) begin
      ipd_cnt_q <= (ipd_ramp_up || ipd_ramp_down) && !ipd_over ? ipd_cnt_q + IW'(1) : '0;
      t1_q      <= (ipd_over && ipd_ramp_up) || (t1_q && !fault_clear);
      t2_q      <= (ipd_over && ipd_ramp_down) || (t2_q && !fault_clear);
      rate_q    <= (ipd_pulse_start && !ipd_current_decayed) || (rate_q && !fault_clear);
    end
  end

  // The trip input already carries the thermal hysteresis, so its fall marks recovery.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_q <= 1'b0;
    end else if (ce) begin
      ot_q <= ot_trip || (ot_q && !(cfg_q.ot_auto || fault_clear));
    end
  end

  // ****************************************
  // Gate drive and reporting
  // ****************************************
  fault_resp_pkg::gate_mode_t mode;
  fault_resp_pkg::gates_t     gates_d;

  always_comb begin
    if (ot_q || t1_q || t2_q || rate_q || (lock_act_q && lock_act_kind_q == 2'h0)) begin
      mode = fault_resp_pkg::GM_PULL_LOW;
    end else if (gate_disable_req) begin
      mode = fault_resp_pkg::GM_DISABLED;
    end else if (lock_act_q) begin
      mode = lock_act_kind_q == 2'h1 ? fault_resp_pkg::GM_RECIRC
           : lock_act_kind_q == 2'h2 ? fault_resp_pkg::GM_HS_BRAKE
           : fault_resp_pkg::GM_LS_BRAKE;
    end else if (cyc_act_q) begin
      mode = fault_resp_pkg::GM_RECIRC;
    end else begin
      mode = fault_resp_pkg::GM_NORMAL;
    end
  end

  // Recirculation turns the conducting high side off and closes its low side instead.
  always_comb begin
    gates_d = '0;
    unique case (mode)
      fault_resp_pkg::GM_NORMAL:   gates_d = gate_cmd;
      fault_resp_pkg::GM_RECIRC:   gates_d.low = gate_cmd.low | gate_cmd.high;
      fault_resp_pkg::GM_HS_BRAKE: gates_d.high = 3'h7;
      fault_resp_pkg::GM_LS_BRAKE: gates_d.low = 3'h7;
      fault_resp_pkg::GM_PULL_LOW: gates_d = '0;
      fault_resp_pkg::GM_DISABLED: gates_d = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_out            <= '0;
      high_semi_pulldown  <= 1'b0;
      low_active_pulldown <= 1'b1;
      fault_indicator_n   <= 1'b1;
      fault_status        <= '0;
    end else if (ce) begin
      gate_out            <= gates_d;
      high_semi_pulldown  <= mode == fault_resp_pkg::GM_DISABLED;
      low_active_pulldown <= mode != fault_resp_pkg::GM_DISABLED;
      fault_indicator_n   <= !(stat.ctrl_fault || stat.drv_fault);
      fault_status        <= stat;
    end
  end

  always_comb begin
    stat             = '0;
    stat.cyc_flag    = cyc_act_q || (cm == fault_resp_pkg::CYC_REPORT_ONLY && cyc_cmp);
    stat.lock_fault  = lock_rep;
    stat.timeout_one = t1_q;
    stat.timeout_two = t2_q;
    stat.pulse_rate  = rate_q;
    stat.ctrl_fault  = cyc_rep || lock_rep || t1_q || t2_q || rate_q;
    stat.ot_shutdown = ot_q;
    stat.drv_fault   = ot_q;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cyc_detect: assert property (ce && cyc_cmp && cm < fault_resp_pkg::CYC_REPORT_ONLY
                                 |=> cyc_act_q)
    else $error("Cycle limit event not captured.");
  a_next_pwm: assert property (ce && cyc_act_q && cm < 4'h2 && pwm_cycle_start && !cyc_cmp
                               |=> !cyc_act_q)
    else $error("Cycle limit not released at PWM start.");
  a_thresh_hold: assert property (ce && cyc_act_q && cm[3:1] == 3'h1 && cyc_cmp
                                  |=> cyc_act_q && gate_out.high == 3'h0)
    else $error("Threshold mode released while current high.");
  a_retry_release: assert property (ce && cyc_act_q && cm[3:1] == 3'h2 && !cyc_cmp
      && pwm_cycle_start && pwm_cnt_q >= {1'b0, cfg_q.retry_count} |=> !cyc_act_q)
    else $error("Retry mode did not release.");
  a_report_only: assert property (ce && cm >= fault_resp_pkg::CYC_REPORT_ONLY
                                  |=> !cyc_act_q)
    else $error("Report only mode acted on gates.");
  a_lock_latch: assert property (ce && lock_act_q && !cfg_q.lock_mode[2] && !fault_clear
                                 |=> lock_act_q)
    else $error("Latched lock fault released without clear.");
  a_ipd_timeout: assert property (ce && ipd_ramp_up && ipd_over |=> t1_q ##1 !fault_indicator_n)
    else $error("Position timeout not latched.");
  a_pulse_rate: assert property (ce && ipd_pulse_start && !ipd_current_decayed
                                 |=> rate_q)
    else $error("Pulse rate fault not latched.");
  a_ot_pull_low: assert property (ce && ot_q |=> gate_out == '0 && low_active_pulldown)
    else $error("Overtemperature did not pull gates low.");
  a_ot_latched: assert property (ce && ot_q && !cfg_q.ot_auto && !fault_clear |=> ot_q)
    else $error("Latched shutdown released without clear.");
  a_disabled_pd: assert property (ce && mode == fault_resp_pkg::GM_DISABLED
                                  |=> high_semi_pulldown && !low_active_pulldown)
    else $error("Disabled gate pull-downs wrong.");

  c_cyc_recover: cover property (cyc_act_q ##[1:20] !cyc_act_q);
  c_lock_retry: cover property (lock_act_q && cfg_q.lock_mode[2] ##1 !lock_act_q);
  c_ot_auto: cover property (ot_q && cfg_q.ot_auto ##1 !ot_q);

endmodule

// file: pkg/fault_resp_pkg.sv
// Package with the register map, field layout, timing figures and carrier types of the fault logic.
package fault_resp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned IPD_TIMEOUT_MS  = 500;
  localparam int unsigned LOCK_RETRY_MS   = 100;
  localparam int unsigned IPD_TIMEOUT_CYC = IPD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_RETRY_CYC  = LOCK_RETRY_MS * (CLK_HZ / 1000);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  CONFIG_OFS  = 8'h00;
  localparam logic [7:0]  CLEAR_OFS   = 8'h04;
  localparam logic [7:0]  STATUS_OFS  = 8'h08;
  localparam logic [31:0] CONFIG_RST  = 32'h0000_0000;
  localparam int unsigned CYC_MODE_LSB  = 0;
  localparam int unsigned LOCK_MODE_LSB = 4;
  localparam int unsigned OT_AUTO_BIT   = 8;
  localparam int unsigned RETRY_LSB     = 16;
  localparam int unsigned CLEAR_BIT     = 0;

  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [3:0] CYC_NEXT_PWM_REP  = 4'h0;
  localparam logic [3:0] CYC_THRESH_REP    = 4'h2;
  localparam logic [3:0] CYC_RETRY_REP     = 4'h4;
  localparam logic [3:0] CYC_REPORT_ONLY   = 4'h6;
  localparam logic [3:0] LOCK_REPORT_ONLY  = 4'h8;

  typedef struct packed {
    logic [7:0] retry_count;
    logic       ot_auto;
    logic [3:0] lock_mode;
    logic [3:0] cyc_mode;
  } config_t;

  typedef struct packed {
    logic drv_fault;
    logic ot_shutdown;
    logic pulse_rate;
    logic timeout_two;
    logic timeout_one;
    logic lock_fault;
    logic ctrl_fault;
    logic cyc_flag;
  } status_t;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gates_t;

  typedef enum logic [2:0] {
    GM_NORMAL, GM_RECIRC, GM_HS_BRAKE, GM_LS_BRAKE, GM_PULL_LOW, GM_DISABLED
  } gate_mode_t;

endpackage

// file: testbench/half_bridge_model.sv
// Behavioural model of the external half-bridges and their current sense comparators.
`timescale 1ns/1ps
module half_bridge_model #(
  parameter logic [7:0] CYC_THR  = 8'h40,
  parameter logic [7:0] LOCK_THR = 8'h80
) (
  input  wire logic                   pclk,
  input  wire fault_resp_pkg::gates_t gate_out,
  input  wire logic [7:0]             motor_current,
  output logic                        cycle_cmp,
  output logic                        lock_cmp,
  output logic                        shoot_through
);
  // The comparators are analog, so they follow the current with no clock.
  assign cycle_cmp = motor_current > CYC_THR;
  assign lock_cmp  = motor_current > LOCK_THR;
  // A leg with both switches on shorts the supply, which no response may ever cause.
  always_ff @(posedge pclk) begin
    shoot_through <= |(gate_out.high & gate_out.low);
  end
endmodule

// file: testbench/motor_fault_response_logic_tb.sv
// Self-checking testbench of the fault-response logic.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module motor_fault_response_logic_tb;
  // ****************************************
  // Signals
  // ****************************************
  // Short counts keep the run brief; the timeout and retry waits below are derived from them.
  localparam int unsigned            TO_CYC    = 20;
  localparam int unsigned            RETRY_CYC = 20;
  localparam fault_resp_pkg::gates_t ZERO_G    = '0;
  logic                   pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]             paddr, cur;
  logic [31:0]            pwdata, prdata, rd;
  logic                   cyc_cmp, lock_cmp, ot_trip, pwm_start, ramp_up, ramp_dn;
  logic                   pulse, decayed, dis_req, semi_pd, act_pd, fault_n, shoot;
  fault_resp_pkg::gates_t cmd, gout, recirc;
  fault_resp_pkg::status_t st;
  int                     err_count, n_tests;

  fault_resp #(.IPD_TIMEOUT_CYCLES(TO_CYC), .LOCK_RETRY_CYCLES(RETRY_CYC)) i_fault_resp (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cycle_cmp_in(cyc_cmp), .lock_cmp_in(lock_cmp),
    .overtemp_trip_in(ot_trip), .pwm_cycle_start(pwm_start), .ipd_ramp_up(ramp_up),
    .ipd_ramp_down(ramp_dn), .ipd_pulse_start(pulse), .ipd_current_decayed(decayed),
    .gate_disable_req(dis_req), .gate_cmd(cmd), .gate_out(gout),
    .high_semi_pulldown(semi_pd), .low_active_pulldown(act_pd),
    .fault_indicator_n(fault_n), .fault_status(st));

  half_bridge_model i_half_bridge_model (
    .pclk(pclk), .gate_out(gout), .motor_current(cur), .cycle_cmp(cyc_cmp),
    .lock_cmp(lock_cmp), .shoot_through(shoot));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function automatic logic [31:0] cfg(logic [3:0] cm, logic [3:0] lm, logic ot, logic [7:0] rc);
    cfg = {8'h00, rc, 7'h00, ot, lm, cm};
  endfunction

  task automatic pwm_pulse();
    @(posedge pclk);
    pwm_start <= 1'b1;
    @(posedge pclk);
    pwm_start <= 1'b0;
  endtask

  // Waits well past the four-edge path from a comparator pin to the outputs.
  task automatic expect_out(input fault_resp_pkg::gates_t g, input logic fn,
                            input logic [7:0] s, input logic [7:0] m);
    repeat (8) @(posedge pclk);
    #1;
    `CHK(gout, g)
    `CHK(fault_n, fn)
    `CHK(st & m, s)
    `CHK(shoot, 1'b0)
    `CHK(act_pd, 1'b1)
  endtask

  task automatic cyc_case(input logic [3:0] m);
    logic rc;
    logic rp;
    rc = (m < 4'h6);
    rp = rc ? ~m[0] : (m == 4'h6);
    apb(1'b1, fault_resp_pkg::CONFIG_OFS, cfg(m, 4'h9, 1'b0, 8'h02));
    cur <= 8'h50;
    expect_out(rc ? recirc : cmd, ~rp, {6'h0, rp, rc}, rc ? 8'h03 : 8'h02);
    cur <= 8'h00;
    if (!rc) expect_out(cmd, 1'b1, 8'h00, 8'h03);
    else if (m[2:1] == 2'b01) expect_out(cmd, 1'b1, 8'h00, 8'h03);
    else begin
      expect_out(recirc, ~rp, {6'h0, rp, 1'b1}, 8'h03);
      repeat (m[2] ? 2 : 0) pwm_pulse();
      if (m[2]) expect_out(recirc, ~rp, {6'h0, rp, 1'b1}, 8'h03);
      pwm_pulse();
      expect_out(cmd, 1'b1, 8'h00, 8'h03);
    end
  endtask

  function automatic fault_resp_pkg::gates_t lock_gates(input logic [1:0] a);
    case (a)
      2'd0: lock_gates = ZERO_G;
      2'd1: lock_gates = recirc;
      2'd2: lock_gates = '{high: 3'b111, low: 3'b000};
      default: lock_gates = '{high: 3'b000, low: 3'b111};
    endcase
  endfunction

  task automatic lock_case(input logic [3:0] m);
    apb(1'b1, fault_resp_pkg::CONFIG_OFS, cfg(4'h7, m, 1'b0, 8'h00));
    cur <= 8'hc0;
    expect_out(m[3] ? cmd : lock_gates(m[1:0]), m > 4'h8, {5'h0, m <= 4'h8, 2'h0}, 8'h04);
    cur <= 8'h00;
    expect_out(m[3] ? cmd : lock_gates(m[1:0]), m[3], {5'h0, ~m[3], 2'h0}, 8'h04);
    if (!m[3]) begin
      repeat (RETRY_CYC + 10) @(posedge pclk);
      expect_out(m[2] ? cmd : lock_gates(m[1:0]), m[2], {5'h0, ~m[2], 2'h0}, 8'h04);
      apb(1'b1, fault_resp_pkg::CLEAR_OFS, 32'h0000_0001);
      expect_out(cmd, 1'b1, 8'h00, 8'h04);
    end
  endtask

  task automatic latched_case(input logic [7:0] b);
    ramp_up <= b[3]; ramp_dn <= b[4]; decayed <= ~b[5]; ot_trip <= b[6]; pulse <= b[5];
    @(posedge pclk);
    pulse <= 1'b0;
    repeat (TO_CYC + 4) @(posedge pclk);
    expect_out(ZERO_G, 1'b0, b, b);
    ramp_up <= 1'b0; ramp_dn <= 1'b0; decayed <= 1'b1; ot_trip <= 1'b0;
    expect_out(ZERO_G, 1'b0, b, b);
    apb(1'b1, fault_resp_pkg::CLEAR_OFS, 32'h0000_0001);
    expect_out(cmd, 1'b1, 8'h00, b);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    err_count = 0; n_tests = 0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; cur = 8'h00; ot_trip = 1'b0;
    pwm_start = 1'b0; ramp_up = 1'b0; ramp_dn = 1'b0; pulse = 1'b0; decayed = 1'b1;
    dis_req = 1'b0; cmd = '{high: 3'b001, low: 3'b010}; recirc = '{high: 3'b000, low: 3'b011};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fault_resp_pkg::STATUS_OFS, 32'h0);
    `CHK(rd, 32'h0000_0000)
    `CHK(fault_n, 1'b1)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(serr, 1'b1)
    apb(1'b1, fault_resp_pkg::CONFIG_OFS, cfg(4'h2, 4'h9, 1'b1, 8'h5a));
    apb(1'b0, fault_resp_pkg::CONFIG_OFS, 32'h0);
    `CHK(rd, 32'h005a_0192)
    for (int m = 0; m < 9; m++) cyc_case(m[3:0]);
    cyc_case(4'hf);
    for (int m = 0; m < 10; m++) lock_case(m[3:0]);
    latched_case(8'h08);
    latched_case(8'h10);
    latched_case(8'h20);
    latched_case(8'h40);
    apb(1'b1, fault_resp_pkg::CONFIG_OFS, cfg(4'h7, 4'h9, 1'b1, 8'h00));
    ot_trip <= 1'b1;
    expect_out(ZERO_G, 1'b0, 8'h40, 8'h40);
    ot_trip <= 1'b0;
    expect_out(cmd, 1'b1, 8'h00, 8'h40);
    dis_req <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    `CHK(semi_pd, 1'b1)
    `CHK(act_pd, 1'b0)
    `CHK(gout, ZERO_G)
    // A write while the clock enable is low must be lost.
    ce <= 1'b0;
    apb(1'b1, fault_resp_pkg::CONFIG_OFS, 32'h0000_0000);
    ce <= 1'b1;
    apb(1'b0, fault_resp_pkg::CONFIG_OFS, 32'h0);
    `CHK(rd, 32'h0000_0197)
    report_and_stop();
  end

  // The tests need about eleven hundred cycles; sixty thousand means a hang.
  initial begin
    #3_000_000;
    err_count++;
    report_and_stop();
  end
endmodule
